// File: shared/ppg_pair_consts.svh
`ifndef PPG_PAIR_CONSTS_SVH
`define PPG_PAIR_CONSTS_SVH

// Register offsets on the plain register port.
`define OFS_CYC_LO   4'h0
`define OFS_DUTY_LO  4'h1
`define OFS_CMP_HI   4'h2
`define OFS_DUTY_HI  4'h3
`define OFS_MODE_LO  4'h4
`define OFS_MODE_HI  4'h5
`define OFS_CTRL     4'h6
`define OFS_CNT_LO   4'h7
`define OFS_CNT_HI   4'h8

// Mode field codes.
`define MODE_PPG     2'b10
`define MODE_T16A    2'b00
`define MODE_T16B    2'b01

// Field positions inside the pair control register.
`define CTRL_RUN_LO  0
`define CTRL_RUN_HI  1
`define CTRL_CASC    2
`define CTRL_AND     3
`define CTRL_W       4

// Reset values.
`define MODE_RST     8'h00
`define CTRL_RST     8'h00
`define CMP_RST      8'h00
`define CNT_RST      8'h00

// Source clock dividers as powers of two, one per clock select code.
`define PRE_W        11
`define DIV_SEL0     4'd11
`define DIV_SEL1     4'd10
`define DIV_SEL2     4'd8
`define DIV_SEL3     4'd6
`define DIV_SEL4     4'd4
`define DIV_SEL5     4'd2
`define DIV_SEL6     4'd1
`define DIV_SEL7     4'd0

`endif

// File: shared/ppg_pair_pkg.sv
`include "ppg_pair_consts.svh"

package ppg_pair_pkg;

  typedef struct packed {
    logic       dbuf_enable;
    logic       initial_level;
    logic [1:0] mode_field;
    logic       ext_input_select;
    logic [2:0] clock_select;
  } mode_t;

  typedef struct packed {
    logic [3:0] rsvd;
    logic       and_output_select;
    logic       cascade_bit;
    logic       run_hi;
    logic       run_lo;
  } control_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } bus_req_t;

  typedef struct packed {
    logic [`PRE_W-1:0] pre;
    logic              tick;
  } tick_state_t;

  typedef struct packed {
    mode_t          mode_reg_lo;
    mode_t          mode_reg_hi;
    control_t       pair_control;
    logic [1:0][7:0] cyc_buf;
    logic [1:0][7:0] cyc_act;
    logic [1:0][7:0] duty_buf;
    logic [1:0][7:0] duty_act;
    logic [7:0]     lo_stage;
    logic [1:0][7:0] cnt;
    logic [1:0]     pout;
    logic           pin_lo;
    logic           pin_hi;
    logic [1:0]     irq;
    logic [7:0]     rdata;
  } pair_state_t;

endpackage

// File: design/source_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppg_pair_consts.svh"

module source_tick
  import ppg_pair_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic [2:0] sel,
  // Source clock pulse
  output logic            tick
);

  tick_state_t s_reg;
  tick_state_t s_next;

  function automatic logic [`PRE_W-1:0] sel_mask(input logic [2:0] code);
    logic [3:0] sh;
    sh = `DIV_SEL7;
    case (code)
      3'h0: sh = `DIV_SEL0;
      3'h1: sh = `DIV_SEL1;
      3'h2: sh = `DIV_SEL2;
      3'h3: sh = `DIV_SEL3;
      3'h4: sh = `DIV_SEL4;
      3'h5: sh = `DIV_SEL5;
      3'h6: sh = `DIV_SEL6;
      default: sh = `DIV_SEL7;
    endcase
    sel_mask = `PRE_W'((12'h001 << sh) - 12'h001);
  endfunction

  // The prescaler restarts with the run bit, so the first count of a run
  // always lasts a full source period.
  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (!run)
    begin
      s_next.pre = '0;
    end
    else if ((s_reg.pre & sel_mask(sel)) == sel_mask(sel))
    begin
      s_next.pre = '0;
      s_next.tick = 1'b1;
    end
    else
    begin
      s_next.pre = s_reg.pre + `PRE_W'(1);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign tick = s_reg.tick;

endmodule

`default_nettype wire

// File: design/ppg_timer_pair.sv
// Notes on behaviour
// - Lower counter is a pulse generator at mode 10, no cascade, no external input.
// - Upper counter works the same way with its own mode, compares and run bit.
// - Mode register writes are dropped while that counter runs; configure first.
// - Initial-level bit picks the idle level of the pulse output.
// - A stopped counter drives its initial level on the pulse output.
// - With AND select set, the lower pin shows the AND of both pulse outputs.
// - Running counter counts source clocks; duty match flips output off idle.
// - Cycle match returns output to idle and raises the counter's interrupt.
// - Clearing run stops the counter, zeroes it, and restores the idle level.
// - Double buffered running writes wait in a buffer until the interrupt.
// - Double buffered compare reads return the buffer, not the active value.
// - A compare write while stopped loads buffer and active value together.
// - Unbuffered running writes act at once; a value below count waits a wrap.
// - Unbuffered write equal to the count matches right after the write.
// - Cascade bit joins both counters; only the upper settings then count.
// - Sixteen-bit timer runs with upper mode 00 or 01 and no external input.
// - Low byte then high byte; the high write commits both bytes together.
// - Upper run starts the 16-bit timer and locks the upper mode register.
// - A 16-bit match raises the upper interrupt and restarts from zero.
// - Clearing upper run in 16-bit mode stops and zeroes the counter.
// - Buffered 16-bit running writes move to the active value on the match.
// - A 16-bit write while stopped loads buffer and active value together.
// - 16-bit compare reads return the buffer in every case; a staged low byte shows only after the high write.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "ppg_pair_consts.svh"

module ppg_timer_pair
  import ppg_pair_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Register port
  input  wire ppg_pair_pkg::bus_req_t bus,
  output logic [7:0]                 rdata,
  // Pulse pins
  output logic                       pulse_out_lo,
  output logic                       pulse_out_hi,
  // Interrupt requests
  output logic                       irq_lo,
  output logic                       irq_hi
);

  pair_state_t s;
  pair_state_t n;

  mode_t      md       [2];
  logic [1:0] runb;
  logic [1:0] ppg_on;
  logic [1:0] live;
  logic [1:0] tk;
  logic [1:0] wr_cyc;
  logic [1:0] wr_dut;
  logic [1:0] m_cyc;
  logic [1:0] m_duty;
  logic       casc16;
  logic       run16;
  logic       wr_lo16;
  logic       wr_hi16;
  logic       m16;
  logic [15:0] cnt16;
  logic [15:0] act16;
  logic [15:0] new16;

  function automatic logic [7:0] cmp_view(input logic dbuf, input logic [7:0] bf,
                                          input logic [7:0] act);
    cmp_view = dbuf ? bf : act;
  endfunction

  function automatic logic hit(input bus_req_t b, input logic [3:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction

  assign md[0] = s.mode_reg_lo;
  assign md[1] = s.mode_reg_hi;
  assign runb  = {s.pair_control.run_hi, s.pair_control.run_lo};

  source_tick u_tick_lo (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (live[0]),
    .sel     (s.mode_reg_lo.clock_select),
    .tick    (tk[0])
  );

  // The upper prescaler also feeds the joined 16-bit counter.
  source_tick u_tick_hi (
    .clk_sys (clk_sys),
    .rst     (rst),
    .run     (live[1] || run16),
    .sel     (s.mode_reg_hi.clock_select),
    .tick    (tk[1])
  );

  always_comb
  begin
    n = s;
    n.irq = 2'b00;
    n.rdata = 8'h00;
    ppg_on = 2'b00;
    live = 2'b00;
    wr_cyc = 2'b00;
    wr_dut = 2'b00;
    m_cyc = 2'b00;
    m_duty = 2'b00;

    if (hit(bus, `OFS_MODE_LO) && !s.pair_control.run_lo)
    begin
      n.mode_reg_lo = mode_t'(bus.wdata);
    end
    if (hit(bus, `OFS_MODE_HI) && !s.pair_control.run_hi)
    begin
      n.mode_reg_hi = mode_t'(bus.wdata);
    end
    if (hit(bus, `OFS_CTRL))
    begin
      n.pair_control = control_t'({4'h0, bus.wdata[`CTRL_W-1:0]});
    end

    casc16 = s.pair_control.cascade_bit;
    run16 = casc16 && s.pair_control.run_hi && !s.mode_reg_hi.ext_input_select &&
            ((s.mode_reg_hi.mode_field == `MODE_T16A) ||
             (s.mode_reg_hi.mode_field == `MODE_T16B));

    for (int c = 0; c < 2; c++)
    begin
      ppg_on[c] = (md[c].mode_field == `MODE_PPG) && !casc16 && !md[c].ext_input_select;
      live[c] = ppg_on[c] && runb[c];
      wr_cyc[c] = !casc16 && hit(bus, (c == 0) ? `OFS_CYC_LO : `OFS_CMP_HI);
      wr_dut[c] = hit(bus, (c == 0) ? `OFS_DUTY_LO : `OFS_DUTY_HI);

      if (wr_cyc[c])
      begin
        n.cyc_buf[c] = bus.wdata;
        if (!(live[c] && md[c].dbuf_enable))
        begin
          n.cyc_act[c] = bus.wdata;
        end
      end
      if (wr_dut[c])
      begin
        n.duty_buf[c] = bus.wdata;
        if (!(live[c] && md[c].dbuf_enable))
        begin
          n.duty_act[c] = bus.wdata;
        end
      end

      // unbuffered write equal to count matches at once
      m_cyc[c] = live[c] &&
                 ((tk[c] && (s.cnt[c] == s.cyc_act[c])) ||
                  (wr_cyc[c] && !md[c].dbuf_enable && (bus.wdata == s.cnt[c])));
      m_duty[c] = live[c] &&
                  ((tk[c] && (s.cnt[c] == s.duty_act[c])) ||
                   (wr_dut[c] && !md[c].dbuf_enable && (bus.wdata == s.cnt[c])));

      if (!live[c])
      begin
        n.cnt[c] = `CNT_RST;
        n.pout[c] = md[c].initial_level;
      end
      else if (m_cyc[c])
      begin
        n.cnt[c] = `CNT_RST;
        n.pout[c] = md[c].initial_level;
        n.irq[c] = 1'b1;
        if (md[c].dbuf_enable)
        begin
          n.cyc_act[c] = n.cyc_buf[c];
          n.duty_act[c] = n.duty_buf[c];
        end
      end
      else
      begin
        if (m_duty[c])
        begin
          n.pout[c] = !md[c].initial_level;
        end
        if (tk[c])
        begin
          n.cnt[c] = s.cnt[c] + 8'h01;
        end
      end
    end

    // low byte staged, high byte commits
    wr_lo16 = casc16 && hit(bus, `OFS_CYC_LO);
    wr_hi16 = casc16 && hit(bus, `OFS_CMP_HI);
    new16 = {bus.wdata, s.lo_stage};
    cnt16 = {s.cnt[1], s.cnt[0]};
    act16 = {s.cyc_act[1], s.cyc_act[0]};
    m16 = 1'b0;
    if (casc16)
    begin
      if (wr_lo16)
      begin
        n.lo_stage = bus.wdata;
      end
      if (wr_hi16)
      begin
        n.cyc_buf[1] = bus.wdata;
        n.cyc_buf[0] = s.lo_stage;
        if (!(run16 && s.mode_reg_hi.dbuf_enable))
        begin
          n.cyc_act[1] = bus.wdata;
          n.cyc_act[0] = s.lo_stage;
        end
      end
      m16 = run16 &&
            ((tk[1] && (cnt16 == act16)) ||
             (wr_hi16 && !s.mode_reg_hi.dbuf_enable && (new16 == cnt16)));
      if (!run16)
      begin
        {n.cnt[1], n.cnt[0]} = {`CNT_RST, `CNT_RST};
      end
      else if (m16)
      begin
        {n.cnt[1], n.cnt[0]} = {`CNT_RST, `CNT_RST};
        n.irq[1] = 1'b1;
        if (s.mode_reg_hi.dbuf_enable)
        begin
          n.cyc_act = n.cyc_buf;
        end
      end
      else if (tk[1])
      begin
        {n.cnt[1], n.cnt[0]} = cnt16 + 16'h0001;
      end
    end

    // AND combination on the lower pin
    n.pin_lo = s.pair_control.and_output_select ? (n.pout[0] & n.pout[1]) : n.pout[0];
    n.pin_hi = n.pout[1];

    // Read decode; unmapped offsets read as zero.
    if (bus.rd)
    begin
      if (bus.addr == `OFS_CYC_LO)
      begin
        n.rdata = casc16 ? s.cyc_buf[0] :
                  cmp_view(md[0].dbuf_enable, s.cyc_buf[0], s.cyc_act[0]);
      end
      else if (bus.addr == `OFS_DUTY_LO)
      begin
        n.rdata = cmp_view(md[0].dbuf_enable, s.duty_buf[0], s.duty_act[0]);
      end
      else if (bus.addr == `OFS_CMP_HI)
      begin
        n.rdata = casc16 ? s.cyc_buf[1] :
                  cmp_view(md[1].dbuf_enable, s.cyc_buf[1], s.cyc_act[1]);
      end
      else if (bus.addr == `OFS_DUTY_HI)
      begin
        n.rdata = cmp_view(md[1].dbuf_enable, s.duty_buf[1], s.duty_act[1]);
      end
      else if (bus.addr == `OFS_MODE_LO)
      begin
        n.rdata = s.mode_reg_lo;
      end
      else if (bus.addr == `OFS_MODE_HI)
      begin
        n.rdata = s.mode_reg_hi;
      end
      else if (bus.addr == `OFS_CTRL)
      begin
        n.rdata = s.pair_control;
      end
      else if (bus.addr == `OFS_CNT_LO)
      begin
        n.rdata = s.cnt[0];
      end
      else if (bus.addr == `OFS_CNT_HI)
      begin
        n.rdata = s.cnt[1];
      end
      else
      begin
        n.rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s <= '0;
      s.mode_reg_lo <= mode_t'(`MODE_RST);
      s.mode_reg_hi <= mode_t'(`MODE_RST);
      s.pair_control <= control_t'(`CTRL_RST);
      s.cyc_buf <= {`CMP_RST, `CMP_RST};
      s.cyc_act <= {`CMP_RST, `CMP_RST};
      s.duty_buf <= {`CMP_RST, `CMP_RST};
      s.duty_act <= {`CMP_RST, `CMP_RST};
    end
    else
    begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign pulse_out_lo = s.pin_lo;
  assign pulse_out_hi = s.pin_hi;
  assign irq_lo = s.irq[0];
  assign irq_hi = s.irq[1];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_mode_lock;
    s.pair_control.run_lo && hit(bus, `OFS_MODE_LO) && !hit(bus, `OFS_CTRL)
      |=> $stable(s.mode_reg_lo);
  endproperty
  a_mode_lock: assert property (p_mode_lock)
    else $error("mode register changed while counter running");

  property p_idle_level;
    !live[0] |=> (s.pout[0] == $past(s.mode_reg_lo.initial_level));
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("stopped pulse output not at initial level");

  property p_stop_clear;
    !live[0] && !casc16 |=> (s.cnt[0] == 8'h00);
  endproperty
  a_stop_clear: assert property (p_stop_clear)
    else $error("stopped counter not cleared");

  property p_and_out;
    $past(s.pair_control.and_output_select) |-> (pulse_out_lo == (s.pout[0] & s.pout[1]));
  endproperty
  a_and_out: assert property (p_and_out)
    else $error("lower pin is not the AND of both outputs");

  property p_duty_flip;
    m_duty[0] && !m_cyc[0] |=> (s.pout[0] == !$past(s.mode_reg_lo.initial_level));
  endproperty
  a_duty_flip: assert property (p_duty_flip)
    else $error("duty match did not invert output");

  property p_count_step;
    live[0] && tk[0] && !m_cyc[0] |=> (s.cnt[0] == 8'($past(s.cnt[0]) + 8'h01));
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not advance on source clock");

  property p_cyc_match;
    m_cyc[0] |=> irq_lo && (s.cnt[0] == 8'h00) ##1 !irq_lo;
  endproperty
  a_cyc_match: assert property (p_cyc_match)
    else $error("cycle match did not pulse interrupt and clear count");

  property p_dbuf_hold;
    live[0] && s.mode_reg_lo.dbuf_enable && wr_cyc[0] && !m_cyc[0]
      |=> $stable(s.cyc_act[0]) && (s.cyc_buf[0] == $past(bus.wdata));
  endproperty
  a_dbuf_hold: assert property (p_dbuf_hold)
    else $error("buffered compare write reached active value early");

  property p_stop_load;
    wr_cyc[0] && !live[0]
      |=> (s.cyc_act[0] == $past(bus.wdata)) && (s.cyc_buf[0] == $past(bus.wdata));
  endproperty
  a_stop_load: assert property (p_stop_load)
    else $error("stopped compare write did not load both registers");

  property p_m16;
    m16 |=> irq_hi && ({s.cnt[1], s.cnt[0]} == 16'h0000);
  endproperty
  a_m16: assert property (p_m16)
    else $error("16-bit match did not raise interrupt and clear");

  property p_stop16;
    casc16 && !run16 |=> ({s.cnt[1], s.cnt[0]} == 16'h0000);
  endproperty
  a_stop16: assert property (p_stop16)
    else $error("stopped 16-bit counter not cleared");

  property p_read16;
    bus.rd && casc16 && (bus.addr == `OFS_CMP_HI) |=> (rdata == $past(s.cyc_buf[1]));
  endproperty
  a_read16: assert property (p_read16)
    else $error("16-bit compare read not last written value");

endmodule

`default_nettype wire

// File: testbench/test_ppg_timer_pair.sv
`timescale 1ns/1ps
`default_nettype none
`include "ppg_pair_consts.svh"

module test_ppg_timer_pair;
  import ppg_pair_pkg::*;

  typedef struct {
    logic [3:0] addr;
    logic [7:0] wdata;
    bit         wen;
    logic [7:0] exp;
  } row_t;

  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  bus_req_t   bus = '0;
  logic [7:0] rdata;
  logic       pulse_out_lo;
  logic       pulse_out_hi;
  logic       irq_lo;
  logic       irq_hi;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         irq_lo_seen = 0;
  int         t0;
  int         t1;
  int         t2;
  int         nh;
  row_t       rows [10];

  always #4 clk_sys = ~clk_sys;

  ppg_timer_pair u_dut (
    .clk_sys      (clk_sys),
    .rst          (rst),
    .bus          (bus),
    .rdata        (rdata),
    .pulse_out_lo (pulse_out_lo),
    .pulse_out_hi (pulse_out_hi),
    .irq_lo       (irq_lo),
    .irq_hi       (irq_hi)
  );

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // The whole run needs well under 5000 cycles; the ceiling leaves ample margin.
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (irq_lo === 1'b1)
      irq_lo_seen = irq_lo_seen + 1;
    if (cyc == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task automatic chk_len(input int got, input int exp);
    cmp_count++;
    if (got != exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // Strobe rises on one edge and falls on the next, so calls never collide.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask

  task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    chk_reg(rdata, exp);
  endtask

  task automatic wait_irq(input bit hi, output int t);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    while (((hi ? irq_hi : irq_lo) !== 1'b1) && n < 3000);
    if (n >= 3000)
    begin
      n_mismatch++;
      end_sim();
    end
    t = cyc;
  endtask

  task automatic level_count(input bit hi, input int ncyc, output int n);
    n = 0;
    repeat (ncyc)
    begin
      @(posedge clk_sys);
      #1;
      if ((hi ? pulse_out_hi : pulse_out_lo) === 1'b1)
        n++;
    end
  endtask

  initial
  begin
    rows = '{
      '{`OFS_CTRL,    8'h00, 1'b0, 8'h00},
      '{`OFS_CNT_LO,  8'h00, 1'b0, 8'h00},
      '{4'h9,         8'h00, 1'b0, 8'h00},
      '{`OFS_MODE_LO, 8'h27, 1'b1, 8'h27},
      '{`OFS_MODE_HI, 8'h67, 1'b1, 8'h67},
      '{`OFS_CYC_LO,  8'h03, 1'b1, 8'h03},
      '{`OFS_DUTY_LO, 8'h01, 1'b1, 8'h01},
      '{`OFS_CMP_HI,  8'h05, 1'b1, 8'h05},
      '{`OFS_DUTY_HI, 8'h02, 1'b1, 8'h02},
      '{4'hF,         8'h55, 1'b1, 8'h00}
    };
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk_bit(pulse_out_lo, 1'b0);
    chk_bit(irq_lo, 1'b0);
    foreach (rows[i])
    begin
      if (rows[i].wen)
        wr_reg(rows[i].addr, rows[i].wdata);
      chk_rd(rows[i].addr, rows[i].exp);
    end
    wr_reg(`OFS_CTRL, 8'hF0);
    chk_rd(`OFS_CTRL, 8'h00);
    chk_bit(pulse_out_hi, 1'b1);

    wr_reg(`OFS_CTRL, 8'h01);
    wait_irq(1'b0, t0);
    level_count(1'b0, 4, nh);
    chk_len(nh, 2);
    wait_irq(1'b0, t1);
    wait_irq(1'b0, t2);
    chk_len(t2 - t1, 4);
    wr_reg(`OFS_MODE_LO, 8'h67);
    chk_rd(`OFS_MODE_LO, 8'h27);
    wait_irq(1'b0, t0);
    wr_reg(`OFS_CYC_LO, 8'h07);
    wait_irq(1'b0, t1);
    chk_len(t1 - t0, 8);

    wr_reg(`OFS_CTRL, 8'h03);
    wait_irq(1'b1, t0);
    level_count(1'b1, 6, nh);
    chk_len(nh, 3);
    wait_irq(1'b1, t1);
    wait_irq(1'b1, t2);
    chk_len(t2 - t1, 6);
    wr_reg(`OFS_CTRL, 8'h00);
    chk_rd(`OFS_CNT_LO, 8'h00);
    chk_rd(`OFS_CNT_HI, 8'h00);
    chk_bit(pulse_out_lo, 1'b0);
    chk_bit(pulse_out_hi, 1'b1);

    // Lower counter stopped at a high idle level, so the AND follows the upper pin.
    wr_reg(`OFS_MODE_LO, 8'h67);
    wr_reg(`OFS_CTRL, 8'h0A);
    nh = 0;
    repeat (24)
    begin
      @(posedge clk_sys);
      #1;
      chk_bit(pulse_out_lo, pulse_out_hi);
      if (pulse_out_hi === 1'b0)
        nh++;
    end
    chk_bit(nh > 0, 1'b1);

    wr_reg(`OFS_CTRL, 8'h00);
    wr_reg(`OFS_MODE_LO, 8'hA7);
    wr_reg(`OFS_CYC_LO, 8'h03);
    wr_reg(`OFS_CTRL, 8'h01);
    wait_irq(1'b0, t0);
    wr_reg(`OFS_CYC_LO, 8'h07);
    wait_irq(1'b0, t1);
    wait_irq(1'b0, t2);
    chk_len(t1 - t0, 4);
    chk_len(t2 - t1, 8);
    chk_rd(`OFS_CYC_LO, 8'h07);

    wr_reg(`OFS_CTRL, 8'h00);
    wr_reg(`OFS_MODE_HI, 8'h07);
    wr_reg(`OFS_CTRL, 8'h04);
    wr_reg(`OFS_CYC_LO, 8'h02);
    wr_reg(`OFS_CMP_HI, 8'h01);
    chk_rd(`OFS_CYC_LO, 8'h02);
    chk_rd(`OFS_CMP_HI, 8'h01);
    t0 = irq_lo_seen;
    wr_reg(`OFS_CTRL, 8'h06);
    wait_irq(1'b1, t1);
    wait_irq(1'b1, t2);
    chk_len(t2 - t1, 259);
    chk_len(irq_lo_seen - t0, 0);
    wr_reg(`OFS_CTRL, 8'h04);
    chk_rd(`OFS_CNT_LO, 8'h00);
    chk_rd(`OFS_CNT_HI, 8'h00);

    wr_reg(`OFS_MODE_HI, 8'h97);
    wr_reg(`OFS_CYC_LO, 8'h10);
    wr_reg(`OFS_CMP_HI, 8'h00);
    wr_reg(`OFS_CTRL, 8'h06);
    wait_irq(1'b1, t0);
    wr_reg(`OFS_CYC_LO, 8'h05);
    wr_reg(`OFS_CMP_HI, 8'h00);
    wait_irq(1'b1, t1);
    wait_irq(1'b1, t2);
    chk_len(t1 - t0, 17);
    chk_len(t2 - t1, 6);
    chk_rd(`OFS_CYC_LO, 8'h05);
    wr_reg(`OFS_MODE_HI, 8'h07);
    chk_rd(`OFS_MODE_HI, 8'h97);

    // An external input selection must keep the lower counter out of pulse mode.
    wr_reg(`OFS_CTRL, 8'h00);
    wr_reg(`OFS_MODE_LO, 8'h2F);
    wr_reg(`OFS_CYC_LO, 8'h03);
    t0 = irq_lo_seen;
    wr_reg(`OFS_CTRL, 8'h01);
    repeat (20) @(posedge clk_sys);
    #1;
    chk_len(irq_lo_seen - t0, 0);
    chk_bit(pulse_out_lo, 1'b0);
    wr_reg(`OFS_CTRL, 8'h00);
    end_sim();
  end
endmodule

`default_nettype wire
